/* dbp_pkg.sv */
/*
 * dbp_pkg: register map, field positions, reset values and prescaler
 * taps of the double buffered pwm channel.
 * assumes a 32-bit apb slave in which each register takes one aligned word.
 */
`default_nettype none

package dbp_pkg;

    // apb address width seen by the channel
    localparam int DBP_ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] DBP_OFS_CTRL = 8'h00;
    localparam logic [7:0] DBP_OFS_PERIOD = 8'h04;
    localparam logic [7:0] DBP_OFS_WIDTH = 8'h08;
    localparam logic [7:0] DBP_OFS_COUNTER = 8'h0C;
    localparam logic [7:0] DBP_OFS_PAIR = 8'h10;

    // field positions of the status, interrupt and control register
    localparam int DBP_BIT_EN = 0;
    localparam int DBP_BIT_POL = 1;
    localparam int DBP_CLK_LSB = 2;
    localparam int DBP_LVL_LSB = 5;
    localparam int DBP_BIT_LOAD = 8;
    localparam int DBP_BIT_FLAG = 15;

    // field positions of the coherent period/width pair register
    localparam int DBP_PAIR_PER_LSB = 16;
    localparam int DBP_PAIR_W_LSB = 0;

    // reset and preset values
    localparam logic [15:0] DBP_CNT_PRESET = 16'h0001;
    localparam logic [15:0] DBP_PER_RESET = 16'h0000;
    localparam logic [15:0] DBP_W_RESET = 16'h0000;
    localparam logic [2:0] DBP_CLK_RESET = 3'h0;
    localparam logic [2:0] DBP_LVL_RESET = 3'h0;

    // prescaler: divide by 2,4,8,16,32,64,128,512 as a power of two
    localparam int DBP_PS_W = 9;
    localparam logic [3:0] DBP_TAP_SHIFT [8] = '{
        4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9
    };

endpackage

`default_nettype wire

/* dbp_tick_if.sv */
/*
 * dbp_tick_if: count clock select and count tick between the channel
 * and its prescaler.
 * assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface dbp_tick_if;
    logic [2:0] clk_sel;
    logic tick;

    // prescaler end
    modport src (
        input clk_sel,
        output tick
    );

    // channel end
    modport snk (
        output clk_sel,
        input tick
    );
endinterface

`default_nettype wire

/* dbp_prescaler.sv */
/*
 * dbp_prescaler: free running divider that gives a one-cycle count
 * enable at the selected tap.
 * assumes clk_sel comes from a register on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module dbp_prescaler
    import dbp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tap select and tick
    dbp_tick_if.src tb
);

    typedef struct packed {
        logic [DBP_PS_W-1:0] cnt;
        logic tick;
    } dbp_ps_state_t;

    dbp_ps_state_t st_r;
    dbp_ps_state_t st_nxt;
    logic [DBP_PS_W:0] one_hot;
    logic [DBP_PS_W-1:0] mask;

    // mask of the low counter bits for the selected divide ratio
    always_comb begin
        one_hot = (DBP_PS_W+1)'(1) << DBP_TAP_SHIFT[tb.clk_sel];
        mask = DBP_PS_W'(one_hot - (DBP_PS_W+1)'(1));
    end

    // tick once each time the masked bits are all ones
    always_comb begin
        st_nxt = st_r;
        st_nxt.cnt = st_r.cnt + DBP_PS_W'(1);
        st_nxt.tick = ((st_r.cnt & mask) == mask);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tb.tick = st_r.tick;

endmodule // dbp_prescaler

`default_nettype wire

/* dbp_pwm_top.sv */
/*
 * dbp_pwm_top: one double buffered pwm channel with its own 16-bit
 * counter, period and width comparators, output flip-flop, period flag
 * with interrupt level, freeze and an apb register slave.
 * assumes apb master on pclk; debug_freeze is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - counter held at one in reset, disabled
// - enabled counter advances once per count tick
// - period match reloads counter with one
// - counter readable live, writes ignored
// - next period copied at boundary or load
// - period match sets output flip-flop
// - period value zero gives 65536 ticks
// - period value one matches every tick
// - next width copied at boundary or load
// - width match clears output, counter untouched
// - width zero holds output cleared
// - width at least period holds output set
// - zero period allows at most 65535 high
// - limit states change only at boundaries
// - pair write at boundary delays transfer
// - pair write mid-period only fills next
// - flag set at start of each period
// - flag requests interrupt at programmed level
// - freeze stops counter, resumes from value
// - clock select picks one of eight taps
// - disabled pin follows polarity bit
// - polarity selects flip-flop level or complement
module dbp_pwm_top
    import dbp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DBP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // debug freeze, asynchronous
    input wire logic debug_freeze,
    // pwm pin and interrupt request level
    output logic pwm_out,
    output logic [2:0] irq_level
);

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] next_per;
        logic [15:0] next_w;
        logic [15:0] act_per;
        logic [15:0] act_w;
        logic out_ff;
        logic flag;
        logic en;
        logic output_polarity_bit;
        logic [2:0] clk_sel;
        logic [2:0] lvl;
        logic frz_s1;
        logic frz_s2;
        logic pin;
        logic [2:0] irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dbp_state_t;

    localparam dbp_state_t ST_RESET = '{
        cnt: DBP_CNT_PRESET,
        next_per: DBP_PER_RESET,
        next_w: DBP_W_RESET,
        act_per: DBP_PER_RESET,
        act_w: DBP_W_RESET,
        out_ff: 1'b0,
        flag: 1'b0,
        en: 1'b0,
        output_polarity_bit: 1'b0,
        clk_sel: DBP_CLK_RESET,
        lvl: DBP_LVL_RESET,
        frz_s1: 1'b0,
        frz_s2: 1'b0,
        pin: 1'b0,
        irq: 3'h0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

    dbp_state_t st_r;
    dbp_state_t st_nxt;

    // prescaler link
    dbp_tick_if tick_bus ();

    dbp_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .tb(tick_bus.src)
    );

    assign tick_bus.clk_sel = st_r.clk_sel;

    // byte lane merge of a 16-bit register half
    function automatic logic [15:0] merge16(
        input logic [15:0] old_v,
        input logic [15:0] new_v,
        input logic [1:0] lanes
    );
        logic [15:0] r;
        r = old_v;
        if (lanes[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (lanes[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    // decoded apb phases
    logic setup;
    logic wr_acc;
    logic mapped;
    logic [31:0] rd_word;

    // transfer and sequencing strobes
    logic load_req;
    logic pair_wr;
    logic flag_clr;
    logic cnt_tick;
    logic boundary;
    logic [15:0] new_per;
    logic [15:0] new_w;

    // apb phase decode; a write lands at the access edge with pready high
    always_comb begin
        setup = psel && !penable;
        wr_acc = psel && penable && pwrite && st_r.pready;
    end

    // address decode and read multiplexer
    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            DBP_OFS_CTRL: begin
                rd_word[DBP_BIT_EN] = st_r.en;
                rd_word[DBP_BIT_POL] = st_r.output_polarity_bit;
                rd_word[DBP_CLK_LSB +: 3] = st_r.clk_sel;
                rd_word[DBP_LVL_LSB +: 3] = st_r.lvl;
                rd_word[DBP_BIT_FLAG] = st_r.flag;
            end
            DBP_OFS_PERIOD: begin
                rd_word[15:0] = st_r.next_per;
            end
            DBP_OFS_WIDTH: begin
                rd_word[15:0] = st_r.next_w;
            end
            DBP_OFS_COUNTER: begin
                rd_word[15:0] = st_r.cnt;
            end
            DBP_OFS_PAIR: begin
                rd_word[DBP_PAIR_PER_LSB +: 16] = st_r.next_per;
                rd_word[DBP_PAIR_W_LSB +: 16] = st_r.next_w;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // count enable: prescaler tick, channel enabled, not frozen
    always_comb begin
        cnt_tick = tick_bus.tick && st_r.en && !st_r.frz_s2;
        boundary = cnt_tick && (st_r.cnt == st_r.act_per);
    end

    // next state of the whole channel
    always_comb begin
        st_nxt = st_r;
        load_req = 1'b0;
        pair_wr = 1'b0;
        flag_clr = 1'b0;
        new_per = st_r.next_per;
        new_w = st_r.next_w;

        // freeze synchroniser
        st_nxt.frz_s1 = debug_freeze;
        st_nxt.frz_s2 = st_r.frz_s1;

        // no wait state: answer in the first access cycle
        st_nxt.pready = setup;
        st_nxt.pslverr = setup && !mapped;
        if (setup && !pwrite) begin
            st_nxt.prdata = rd_word;
        end

        // register writes
        if (wr_acc) begin
            unique case (paddr)
                DBP_OFS_CTRL: begin
                    if (pstrb[0]) begin
                        st_nxt.en = pwdata[DBP_BIT_EN];
                        st_nxt.output_polarity_bit = pwdata[DBP_BIT_POL];
                        st_nxt.clk_sel = pwdata[DBP_CLK_LSB +: 3];
                        st_nxt.lvl = pwdata[DBP_LVL_LSB +: 3];
                    end
                    if (pstrb[1]) begin
                        load_req = pwdata[DBP_BIT_LOAD];
                        flag_clr = pwdata[DBP_BIT_FLAG];
                    end
                end
                DBP_OFS_PERIOD: begin
                    st_nxt.next_per = merge16(st_r.next_per,
                        pwdata[15:0], pstrb[1:0]);
                end
                DBP_OFS_WIDTH: begin
                    st_nxt.next_w = merge16(st_r.next_w,
                        pwdata[15:0], pstrb[1:0]);
                end
                DBP_OFS_PAIR: begin
                    // period in the high half, width in the low half
                    st_nxt.next_per = merge16(st_r.next_per,
                        pwdata[DBP_PAIR_PER_LSB +: 16], pstrb[3:2]);
                    st_nxt.next_w = merge16(st_r.next_w,
                        pwdata[DBP_PAIR_W_LSB +: 16], pstrb[1:0]);
                    pair_wr = (pstrb == 4'hF);
                end
                default: begin
                    // counter and unmapped writes have no effect
                    st_nxt.cnt = st_r.cnt;
                end
            endcase
        end

        // flag clear first so that a new period in the same cycle wins
        if (flag_clr) begin
            st_nxt.flag = 1'b0;
        end

        if (!st_r.en) begin
            // disabled: counter preset, active values track the next ones
            st_nxt.cnt = DBP_CNT_PRESET;
            st_nxt.act_per = st_r.next_per;
            st_nxt.act_w = st_r.next_w;
            st_nxt.out_ff = (st_r.next_w != 16'h0000);
        end else begin
            // immediate transfer on a load request
            if (load_req) begin
                st_nxt.act_per = st_r.next_per;
                st_nxt.act_w = st_r.next_w;
            end
            if (boundary) begin
                // a coherent pair write at the boundary keeps old values
                if (pair_wr) begin
                    new_per = st_r.act_per;
                    new_w = st_r.act_w;
                end
                st_nxt.act_per = new_per;
                st_nxt.act_w = new_w;
                st_nxt.cnt = DBP_CNT_PRESET;
                // a width of zero keeps the output low for the period
                st_nxt.out_ff = (new_w != 16'h0000);
                st_nxt.flag = 1'b1;
            end else if (cnt_tick) begin
                // width equal to period never clears: boundary has priority
                st_nxt.cnt = st_r.cnt + 16'h0001;
                if (st_r.cnt == st_r.act_w) begin
                    st_nxt.out_ff = 1'b0;
                end
            end
        end

        // pin: polarity bit alone while disabled
        if (st_nxt.en) begin
            st_nxt.pin = st_nxt.out_ff ^ st_nxt.output_polarity_bit;
        end else begin
            st_nxt.pin = st_nxt.output_polarity_bit;
        end

        // interrupt request level while the flag stands
        st_nxt.irq = st_nxt.flag ? st_nxt.lvl : 3'h0;
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pwm_out = st_r.pin;
    assign irq_level = st_r.irq;

endmodule // dbp_pwm_top

`default_nettype wire

/* dbp_pwm_assertions.sv */
/* dbp_pwm_assertions: port level checks of the pwm channel, and its bind.
   assumes one pclk domain and presetn active low. */
`timescale 1ns/1ps
`default_nettype none
module dbp_pwm_assertions
    import dbp_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DBP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pin side
    input wire logic debug_freeze,
    input wire logic pwm_out,
    input wire logic [2:0] irq_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ctrl_wr, map_ok, en_r, pol_r;
    logic [2:0] lvl_r;
    // control write in access phase and address decode
    assign ctrl_wr = psel && penable && pwrite && paddr == DBP_OFS_CTRL;
    assign map_ok = paddr inside {DBP_OFS_CTRL, DBP_OFS_PERIOD,
        DBP_OFS_WIDTH, DBP_OFS_COUNTER, DBP_OFS_PAIR};
    // shadow of the enable, polarity and level fields as software wrote them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            pol_r <= 1'b0;
            lvl_r <= 3'h0;
        end else if (ctrl_wr && pready && pstrb[0]) begin
            en_r <= pwdata[DBP_BIT_EN];
            pol_r <= pwdata[DBP_BIT_POL];
            lvl_r <= pwdata[DBP_LVL_LSB+:3];
        end
    end
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_rdy_one; pready |-> psel && penable ##1 !pready; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("stray ready");
    property p_err; psel && !penable && !map_ok |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_ok; psel && !penable && map_ok |=> !pslverr; endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_err_rd; pready && pslverr && !pwrite |-> prdata == 0; endproperty
    a_err_rd: assert property (p_err_rd) else $error("unmapped read data");
    property p_ctrl_rd;
        pready && !pwrite && paddr == DBP_OFS_CTRL
        |-> prdata[31:16] == 16'h0 && !prdata[DBP_BIT_LOAD];
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("load bit read");
    property p_dis; !en_r |-> pwm_out == pol_r; endproperty
    a_dis: assert property (p_dis) else $error("disabled pin level");
    property p_irq_lvl; irq_level != 3'h0 |-> irq_level == lvl_r; endproperty
    a_irq_lvl: assert property (p_irq_lvl) else $error("irq level");
    property p_irq_hold; irq_level != 3'h0 && !ctrl_wr |=> $stable(irq_level);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_frz; debug_freeze [*4] ##0 !ctrl_wr |=> $stable(pwm_out);
    endproperty
    a_frz: assert property (p_frz) else $error("pin moved in freeze");
    c_err: cover property (pslverr);
    c_irq: cover property (irq_level != 3'h0);
    c_pulse: cover property (en_r && $rose(pwm_out));
endmodule // dbp_pwm_assertions
bind dbp_pwm_top dbp_pwm_assertions i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .debug_freeze(debug_freeze), .pwm_out(pwm_out),
    .irq_level(irq_level));
`default_nettype wire

/* dbp_pwm_top_test.sv */
/* dbp_pwm_top_test: self-checking bench of the pwm channel over apb.
   assumes dbp_pkg and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module dbp_pwm_top_test import dbp_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic debug_freeze, pwm_out;
    logic [DBP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] irq_level;
    logic [31:0] expq[$];
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    // device under test
    dbp_pwm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_freeze(debug_freeze), .pwm_out(pwm_out), .irq_level(irq_level));
    // 125 MHz clock
    always #4 pclk = ~pclk;
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; a read leaves d as expected data for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            expq.push_back(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic [31:0] cw(input int en, output_polarity_bit, sel, lvl);
        return (en << DBP_BIT_EN) | (output_polarity_bit << DBP_BIT_POL) |
            (sel << DBP_CLK_LSB) | (lvl << DBP_LVL_LSB);
    endfunction
    // disable, load next values, then start with control word c
    task automatic cfg(input int p, input int w, input logic [31:0] c);
        apb(1'b1, DBP_OFS_CTRL, 32'h0);
        apb(1'b1, DBP_OFS_PERIOD, p);
        apb(1'b1, DBP_OFS_WIDTH, w);
        apb(1'b1, DBP_OFS_CTRL, c);
    endtask
    // high time and period of one output pulse in pclk cycles
    task automatic meas(input int hi_e, input int per_e);
        int h, p;
        h = 0;
        // skip the partial period after enable: prescaler phase is unknown
        @(negedge pwm_out);
        @(posedge pwm_out);
        @(negedge pclk);
        while (pwm_out === 1'b1) begin
            h++;
            @(negedge pclk);
        end
        p = h;
        while (pwm_out === 1'b0) begin
            p++;
            @(negedge pclk);
        end
        check(h, hi_e);
        check(p, per_e);
    endtask
    // pin must hold level e for a long stretch
    task automatic steady(input logic e);
        int n;
        n = 0;
        repeat (300) begin
            @(negedge pclk);
            n += int'(pwm_out !== e);
        end
        check(n, 0);
    endtask
    // read data monitor against the oldest expectation
    always @(posedge pclk)
        if (psel && penable && !pwrite && pready === 1'b1)
            check(prdata, expq.pop_front());
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        int i, p, w;
        static int lim[6][4] = '{'{5, 0, 0, 0}, '{4, 4, 0, 1}, '{4, 9, 0, 1},
            '{1, 0, 0, 0}, '{1, 1, 0, 1}, '{5, 0, 1, 1}};
        p = $urandom(32'hd894a916);
        {pclk, presetn, psel, penable, pwrite, debug_freeze} = 6'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, DBP_OFS_CTRL, 32'h0);
        apb(1'b0, DBP_OFS_COUNTER, {16'h0, DBP_CNT_PRESET});
        apb(1'b1, DBP_OFS_COUNTER, 32'h1234);
        apb(1'b0, DBP_OFS_COUNTER, {16'h0, DBP_CNT_PRESET});
        apb(1'b0, 8'h14, 32'h0);
        for (i = 0; i < 4; i++) begin
            p = $urandom;
            apb(1'b1, DBP_OFS_PERIOD, p);
            apb(1'b1, DBP_OFS_WIDTH, ~p);
            apb(1'b0, DBP_OFS_PERIOD, p & 32'hFFFF);
            apb(1'b0, DBP_OFS_WIDTH, ~p & 32'hFFFF);
        end
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            p = 3 + $urandom % 8;
            w = 1 + $urandom % (p - 1);
            cfg(p, w, cw(1, 0, i, 0));
            meas(w << DBP_TAP_SHIFT[i], p << DBP_TAP_SHIFT[i]);
        end
        $display("test taps done");
        for (i = 0; i < 6; i++) begin
            cfg(lim[i][0], lim[i][1], cw(1, lim[i][2], 0, 0));
            steady(lim[i][3] != 0);
        end
        apb(1'b1, DBP_OFS_CTRL, cw(0, 1, 0, 0));
        steady(1'b1);
        $display("test limits done");
        cfg(200, 100, cw(1, 0, 0, 5));
        repeat (450) @(posedge pclk);
        check(irq_level, 5);
        debug_freeze <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, DBP_OFS_CTRL, cw(1, 0, 0, 5) | (1 << DBP_BIT_FLAG));
        apb(1'b1, DBP_OFS_PAIR, {16'd7, 16'd3});
        repeat (1000) @(posedge pclk);
        check(irq_level, 0);
        apb(1'b0, DBP_OFS_CTRL, cw(1, 0, 0, 5));
        apb(1'b0, DBP_OFS_PERIOD, 32'd7);
        apb(1'b0, DBP_OFS_WIDTH, 32'd3);
        debug_freeze <= 1'b0;
        repeat (450) @(posedge pclk);
        check(irq_level, 5);
        apb(1'b1, DBP_OFS_CTRL, cw(1, 0, 0, 0));
        @(negedge pclk);
        check(irq_level, 0);
        $display("test flag done");
        repeat (4) @(posedge pclk);
        results();
    end
endmodule // dbp_pwm_top_test
`default_nettype wire
